// >>> epi_top.sv
// External pin interrupt controller with APB register access.
// Assumes an APB master on pclk; pins are asynchronous to pclk.
// Function
// (RULE1) Pin A polarity write may set flag
// (RULE2) Software clears pin A enable first
// (RULE3) Wait one instruction, then skip-test pin A
// (RULE4) No-op follows pin A skip-test
// (RULE5) Pin A input off while enable zero
// (RULE6) Clear pin A bits before backup
// (RULE7) Pin B enable change may set flag
// (RULE8) Software clears pin B enable first
// (RULE9) Wait one instruction, then skip-test pin B
// (RULE10) No-op follows pin B skip-test
// (RULE11) Pin B input off while enable zero
// (RULE12) Clear pin B bits before backup
// (RULE13) Pin B polarity write may set flag
// (RULE14) Flag needs level held four clocks
// (RULE15) Flag cleared on accept or skip
// (RULE16) Bit3 enables, bit2 selects polarity
// (RULE17) Edge taken from gated polarity-adjusted level
//
// Register access over APB and the register offsets are this design's own decisions.
`include "epi_consts.svh"
module epi_top
   import epi_pkg::*;
#(
   parameter int HOLD = `EPI_HOLD_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_irq_pin_a,
   input  wire logic        ext_irq_pin_b,
   input  wire logic [1:0]  irq_accept,
   output logic [1:0]       irq_req,
   output logic             irq
);
   logic [1:0]  sync1_r;
   logic [1:0]  sync2_r;
   epi_cfg_type cfg_r [2];
   epi_cfg_type cfg_nxt [2];
   logic [1:0]  ctrl_r;
   logic [1:0]  ctrl_nxt;
   logic [1:0]  flag_r;
   logic [1:0]  flag_nxt;
   logic [1:0]  mask_r;
   logic [1:0]  mask_nxt;
   logic [1:0]  skip_nxt;
   logic [1:0]  req_r;
   logic [1:0]  req_nxt;
   logic        irq_r;
   logic        irq_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        pready_r;
   logic        pready_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;
   logic [1:0]  edge_hit;
   logic        wr_en;
   logic        rd_en;
   logic        mapped;

   // Address decode used by read and write paths
   function automatic logic is_mapped(input logic [11:0] a);
      return (a == `EPI_OFF_CFG_A) || (a == `EPI_OFF_CFG_B) || (a == `EPI_OFF_IRQ_CTRL) ||
             (a == `EPI_OFF_STATUS) || (a == `EPI_OFF_MASK) || (a == `EPI_OFF_SKIP);
   endfunction

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
      end else begin
         sync1_r <= {ext_irq_pin_b, ext_irq_pin_a};
         sync2_r <= sync1_r;
      end
   end

   // One detector per pin
   for (genvar g = 0; g < 2; g++) begin : g_pin
      epi_pin_detect #(.HOLD(HOLD)) u_det (
         .pclk     (pclk),
         .presetn  (presetn),
         .pin_sync (sync2_r[g]),
         .cfg      (cfg_r[g]),
         .edge_det (edge_hit[g])
      );
   end

   // Access phase completes in one cycle; pready high in access phase
   assign wr_en  = psel & penable & pwrite & pready_r;   // Write lands at the edge closing access
   assign rd_en  = psel & ~penable & ~pwrite;
   assign mapped = is_mapped(paddr);

   // Register, flag and bus next-state
   always_comb begin
      cfg_nxt     = cfg_r;
      ctrl_nxt    = ctrl_r;
      mask_nxt    = mask_r;
      flag_nxt    = flag_r;
      skip_nxt    = 2'h0;
      prdata_nxt  = prdata_r;
      pready_nxt  = psel & ~penable;
      pslverr_nxt = psel & ~penable & ~is_mapped(paddr);
      // Skip-test: report flag, clear it if set
      if (psel & ~penable & ~pwrite & (paddr == `EPI_OFF_SKIP)) begin
         skip_nxt = flag_r;
      end
      for (int i = 0; i < 2; i++) begin
         if (skip_nxt[i] | (irq_accept[i] & ctrl_r[i] & flag_r[i])) begin
            flag_nxt[i] = 1'b0;                        // see (RULE15) see (RULE3) see (RULE9)
         end
      end
      if (wr_en & mapped) begin
         case (paddr)
            `EPI_OFF_CFG_A:    cfg_nxt[0] = pwdata[3:0];    // see (RULE2) see (RULE6)
            `EPI_OFF_CFG_B:    cfg_nxt[1] = pwdata[3:0];    // see (RULE8) see (RULE12)
            `EPI_OFF_IRQ_CTRL: ctrl_nxt   = pwdata[1:0];
            `EPI_OFF_MASK:     mask_nxt   = pwdata[1:0];
            `EPI_OFF_STATUS:   flag_nxt   = flag_nxt & ~pwdata[1:0];
            default:           ;
         endcase
      end
      // Set wins over any clear in the same cycle
      flag_nxt = flag_nxt | edge_hit;                  // see (RULE14)
      if (rd_en) begin
         case (paddr)
            `EPI_OFF_CFG_A:    prdata_nxt = {28'h0, cfg_r[0]};
            `EPI_OFF_CFG_B:    prdata_nxt = {28'h0, cfg_r[1]};
            `EPI_OFF_IRQ_CTRL: prdata_nxt = {30'h0, ctrl_r};
            `EPI_OFF_STATUS:   prdata_nxt = {30'h0, flag_r};
            `EPI_OFF_MASK:     prdata_nxt = {30'h0, mask_r};
            `EPI_OFF_SKIP:     prdata_nxt = {30'h0, flag_r}; // see (RULE4) see (RULE10)
            default:           prdata_nxt = 32'h0;
         endcase
      end
      req_nxt = flag_r & ctrl_r;
      irq_nxt = |(flag_r & mask_r);
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r[0]  <= `EPI_CFG_RST;
         cfg_r[1]  <= `EPI_CFG_RST;
         ctrl_r    <= `EPI_CTRL_RST;
         mask_r    <= `EPI_MASK_RST;
         flag_r    <= 2'h0;
         req_r     <= 2'h0;
         irq_r     <= 1'b0;
         prdata_r  <= 32'h0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         cfg_r     <= cfg_nxt;
         ctrl_r    <= ctrl_nxt;
         mask_r    <= mask_nxt;
         flag_r    <= flag_nxt;
         req_r     <= req_nxt;
         irq_r     <= irq_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign irq_req = req_r;
   assign irq     = irq_r;
endmodule // epi_top

// >>> epi_consts.svh
// Constants for the external pin interrupt block: offsets, fields, resets, timing.
// Assumes inclusion by the files of this block only; the guard keeps one copy.
`ifndef EPI_CONSTS_SVH
`define EPI_CONSTS_SVH
// Register byte offsets
`define EPI_OFF_CFG_A      12'h000
`define EPI_OFF_CFG_B      12'h004
`define EPI_OFF_IRQ_CTRL   12'h008
`define EPI_OFF_STATUS     12'h00c
`define EPI_OFF_MASK       12'h010
`define EPI_OFF_SKIP       12'h014
// Configuration register fields
`define EPI_CFG_EN_BIT     3
`define EPI_CFG_POL_BIT    2
`define EPI_CFG_BOTH_BIT   1
`define EPI_CFG_SYNC_BIT   0
// Status / mask fields
`define EPI_ST_REQ_A       0
`define EPI_ST_REQ_B       1
// Reset values
`define EPI_CFG_RST        4'h0
`define EPI_CTRL_RST       2'h0
`define EPI_MASK_RST       2'h0
// Least valid level hold, in system clock cycles
`define EPI_HOLD_CYCLES    4
`endif

// >>> epi_pkg.sv
// Types shared by the external pin interrupt block.
// Assumes epi_consts.svh is on the include path.
`include "epi_consts.svh"
package epi_pkg;
   typedef logic [3:0] epi_cfg_type;
   typedef enum logic [1:0] {
      EPI_IDLE,
      EPI_ACCESS
   } epi_bus_state_type;
endpackage

// >>> epi_pin_detect.sv
// One pin's qualification and edge detection.
// Assumes pin_sync is already synchronised to pclk.
`include "epi_consts.svh"
module epi_pin_detect
   import epi_pkg::*;
#(
   parameter int HOLD = `EPI_HOLD_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        pin_sync,
   input  wire epi_cfg_type cfg,
   output logic             edge_det
);
   localparam int CW = $clog2(HOLD + 1);
   logic          stable_r;
   logic          stable_nxt;
   logic          cand_r;
   logic          cand_nxt;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          level_r;
   logic          level_nxt;
   logic          eff;

   // Level filter, then gate and polarity, then edge
   always_comb begin
      stable_nxt = stable_r;
      cand_nxt   = cand_r;
      cnt_nxt    = cnt_r;
      if (pin_sync != cand_r) begin
         cand_nxt = pin_sync;
         cnt_nxt  = CW'(1);
      end else if (cnt_r < CW'(HOLD)) begin
         cnt_nxt = cnt_r + CW'(1);
         if (cnt_r + CW'(1) == CW'(HOLD)) begin
            stable_nxt = cand_r;                       // see (RULE14)
         end
      end
      // Disabled input reads low, polarity folds falling onto rising
      eff = cfg[`EPI_CFG_EN_BIT] & (stable_r ~^ cfg[`EPI_CFG_POL_BIT]); // see (RULE5) see (RULE11) see (RULE16) see (RULE17)
      level_nxt = eff;
      // Config changes move eff and so count as edges
      edge_det  = (eff & ~level_r) |
                  (cfg[`EPI_CFG_BOTH_BIT] & ~eff & level_r); // see (RULE1) see (RULE7) see (RULE13)
   end

   // Filter and edge registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_r <= 1'b0;
         cand_r   <= 1'b0;
         cnt_r    <= '0;
         level_r  <= 1'b0;
      end else begin
         stable_r <= stable_nxt;
         cand_r   <= cand_nxt;
         cnt_r    <= cnt_nxt;
         level_r  <= level_nxt;
      end
   end
endmodule // epi_pin_detect

// >>> epi_pin_src.sv
// Far-side sources that drive the two external interrupt pins.
// Assumes the bench asks for pin levels in step with pclk.
module epi_pin_src (
   input  wire logic       pclk,
   input  wire logic [1:0] want,
   output logic            pin_a,
   output logic            pin_b
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pins move just after an edge; callers hold a level four clocks or more, save one two-clock pulse on pin A
   always_ff @(posedge pclk) begin
      pin_a <= want[0];
      pin_b <= want[1];
   end
endmodule // epi_pin_src

// >>> epi_top_asserts.sv
// Port checker for the external pin interrupt block.
// Assumes it is bound onto epi_top and sees its ports only.
module epi_top_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [1:0]  irq_accept,
   input wire logic [1:0]  irq_req,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answer timing
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_unmapped_err: assert property (psel && !penable && paddr > 12'h014 |=> pslverr)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (psel && !penable && paddr <= 12'h014 && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
   // Accepted request drops
   a_accept_clr_a: assert property (irq_req[0] && irq_accept[0] |-> ##[1:3] !irq_req[0])
      else $error("pin a request kept after accept");
   a_accept_clr_b: assert property (irq_req[1] && irq_accept[1] |-> ##[1:3] !irq_req[1])
      else $error("pin b request kept after accept");
   c_refused: cover property (pready && pslverr);
   c_req_b: cover property ($rose(irq_req[1]));
   c_irq: cover property ($rose(irq));
endmodule // epi_top_asserts
bind epi_top epi_top_asserts u_epi_top_asserts (.*);

// >>> tb_epi_top.sv
// Self-checking bench for the external pin interrupt block.
// Assumes epi_pkg, the pin source model and the checker compile first.
module tb_epi_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, pa, pb, irq;
   logic [1:0]  want = '0, acc = '0, irq_req;
   int          n_errors = 0, checks_done = 0;
   always #10 pclk = ~pclk;
   epi_top u_epi_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ext_irq_pin_a(pa), .ext_irq_pin_b(pb), .irq_accept(acc), .irq_req, .irq);
   epi_pin_src u_epi_pin_src (.pclk, .want, .pin_a(pa), .pin_b(pb));
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic results;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // One APB transfer; read data kept in rd, error in er
   task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
      int i;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1 && i < 20);
      if (i >= 20) begin
         n_errors++;
         results();
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic wflag(int b, logic e);
      int i;
      for (i = 0; i < 30 && irq_req[b] !== e; i++) @(posedge pclk);
      chk("irq_req", irq_req[b], e);
   endtask
   task automatic quiet(int b); // no flag after a settle time
      repeat (20) @(posedge pclk);
      bus(0, 12'h00c, 0);
      chk("status", rd[b], 0);
   endtask
   task automatic s_regs;
      bus(0, 12'h000, 0);
      chk("cfg_a", rd, 0);
      bus(1, 12'h004, 32'hffff_fff3);
      bus(0, 12'h004, 0);
      chk("cfg_b", rd, 32'h3);
      bus(1, 12'h004, 0);
      bus(0, 12'h018, 0);
      chk("unmapped err", er, 1);
      chk("unmapped data", rd, 0);
   endtask
   task automatic s_pin_a;
      bus(1, 12'h008, 3);
      bus(1, 12'h010, 3);
      bus(1, 12'h000, 4'hc);
      want[0] <= 1;
      repeat (2) @(posedge pclk);
      want[0] <= 0;
      quiet(0);
      want[0] <= 1;
      wflag(0, 1);
      chk("irq", irq, 1);
      bus(0, 12'h014, 0);
      chk("skip", rd, 1);
      quiet(0);
      bus(1, 12'h000, 4);
      want[0] <= 0;
      repeat (10) @(posedge pclk);
      want[0] <= 1;
      quiet(0);
      want[0] <= 0;
      repeat (10) @(posedge pclk);
      bus(1, 12'h000, 4'hc);
      bus(1, 12'h000, 8);
      wflag(0, 1);
      acc[0] <= 1;
      @(posedge pclk);
      acc[0] <= 0;
      wflag(0, 0);
   endtask
   task automatic s_pin_b;
      want[1] <= 1;
      bus(1, 12'h004, 4);
      quiet(1);
      bus(1, 12'h004, 4'hc);
      wflag(1, 1);
      bus(1, 12'h00c, 2);
      quiet(1);
      bus(1, 12'h004, 8);
      bus(1, 12'h004, 4'hc);
      wflag(1, 1);
      bus(1, 12'h010, 1);
      @(posedge pclk);
      chk("irq masked", irq, 0);
      acc[1] <= 1;
      @(posedge pclk);
      acc[1] <= 0;
      wflag(1, 0);
   endtask
   // Guarded config change, refused accept, skip-test, both edges, backup
   task automatic s_safe;
      bus(1, 12'h008, 2);
      bus(1, 12'h000, 4'hc);
      bus(1, 12'h000, 8);
      acc[0] <= 1;
      @(posedge pclk);
      acc[0] <= 0;
      @(posedge pclk);
      bus(0, 12'h00c, 0);
      chk("accept gated", rd[0], 1);
      chk("req a gated", irq_req[0], 0);
      bus(0, 12'h014, 0);
      chk("skip a", rd, 1);
      @(posedge pclk);
      bus(0, 12'h00c, 0);
      chk("skip a clr", rd[0], 0);
      bus(1, 12'h000, 4'ha);
      want[0] <= 1;
      repeat (20) @(posedge pclk);
      bus(0, 12'h00c, 0);
      chk("both edges", rd[0], 1);
      bus(1, 12'h00c, 1);
      bus(1, 12'h000, 0);
      want[0] <= 0;
      quiet(0);
      bus(1, 12'h008, 0);
      bus(1, 12'h004, 4);
      bus(1, 12'h004, 4'hc);
      repeat (3) @(posedge pclk);
      chk("req b gated", irq_req[1], 0);
      bus(0, 12'h014, 0);
      chk("skip b", rd, 2);
      @(posedge pclk);
      bus(0, 12'h00c, 0);
      chk("skip b clr", rd[1], 0);
      bus(1, 12'h004, 0);
      want[1] <= 0;
      quiet(1);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      s_regs();
      s_pin_a();
      s_pin_b();
      s_safe();
      results();
   end
   // Hang guard
   initial begin
      #1ms;
      n_errors++;
      results();
   end
endmodule // tb_epi_top
